// ---- rate_multiplier_pkg.sv ----
// Purpose: constants and types for the five-bit binary rate multiplier
// Assumes: one 250 MHz clock, phase clocks arrive as slow sampled levels
// Notes: control words live in a small register file on the bus
package rate_multiplier_pkg;
   localparam int unsigned word_width = 5;        // control word width
   localparam int unsigned addr_width = 4;        // byte address width
   localparam int unsigned data_width = 32;       // bus data width
   localparam int unsigned clk_period_ns = 4;     // 250 MHz clock
   // register byte addresses
   localparam logic [3:0] ctrl_addr = 4'h0;
   localparam logic [3:0] status_addr = 4'h4;
   // field positions in the control register
   localparam int unsigned word1_lsb = 0;
   localparam int unsigned word2_lsb = 8;
   // reset values: phase-1 off (true logic), phase-2 off (inverse logic)
   localparam logic [4:0] word1_reset = 5'h00;
   localparam logic [4:0] word2_reset = 5'h1f;
   localparam logic [4:0] count_last = 5'h1f;     // final state of the chain
   localparam logic [4:0] count_reset = 5'h00;

   // both control words travel together
   typedef struct packed {
      logic [4:0] word2;   // phase-2 word, low bit enables
      logic [4:0] word1;   // phase-1 word, high bit enables
   } ctrl_type;
   localparam ctrl_type ctrl_reset = '{word2: word2_reset, word1: word1_reset};
endpackage : rate_multiplier_pkg

// ---- rate_multiplier.sv ----
// Purpose: five-bit binary rate multiplier with cascade carries
// Assumes: phi1_i and phi2_i are slow levels synchronous to clk_i
// Notes: each output pulse follows its phase clock two clocks late
`timescale 1ns/1ps
`default_nettype none
module rate_multiplier
   import rate_multiplier_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic phi1_i,                          // master phase clock
   input wire logic phi2_i,                          // second phase clock
   input wire logic first_stage_inhibit_in_i,        // high holds the chain
   input wire logic gate_chain_enable_in_i,          // high lets gates pass
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic phase1_out_o,
   output logic phase2_out_o,
   output logic first_stage_inhibit_carry_out_o,
   output logic gate_chain_enable_carry_out_o
);
   ctrl_type ctrl_reg;             // both control words
   logic [4:0] count_reg;          // counter chain state
   logic phi1_d_reg;               // previous phase-1 level
   logic phi2_d_reg;               // previous phase-2 level
   logic hit1_reg;                 // phase-1 pulse selected for this state
   logic hit2_reg;                 // phase-2 pulse selected for this state
   logic wait_reg;                 // bus answer pending
   logic [31:0] rdata_reg;
   logic inh_carry_reg;
   logic en_carry_reg;
   logic [4:0] sel;                // one-hot weight selected by the state, none in state 11111
   logic rise1;
   logic rise2;

   assign rise1 = phi1_i & ~phi1_d_reg;
   assign rise2 = phi2_i & ~phi2_d_reg;

   // disjoint weight decode
   // weight 16 on even states, 8 on xx01, down to 1 on 01111
   genvar g;
   generate
      for (g = 0; g < word_width; g++) begin : g_sel
         assign sel[word_width - 1 - g] = (count_reg[g] == 1'b0) &&
            ((g == 0) ? 1'b1 : (&count_reg[(g == 0 ? 0 : g - 1):0]));
      end
   endgenerate

   // bus slave: one wait cycle, then a single answer cycle
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else if ((read || write) && wait_reg) begin
         wait_reg <= 1'b0;
         // unmapped addresses read as zero
         if (address == ctrl_addr) begin
            rdata_reg <= {19'h00000, ctrl_reg.word2, 3'h0, ctrl_reg.word1};
         end else if (address == status_addr) begin
            rdata_reg <= {25'h0000000, hit1_reg | hit2_reg, 1'b0, count_reg};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end else begin
         wait_reg <= 1'b1;
      end
   end
   assign waitrequest = wait_reg;
   assign readdata = rdata_reg;

   // control words, written at the answer cycle; lane 0 and lane 1
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_reg <= ctrl_reset;
      end else if (write && !wait_reg && address == ctrl_addr) begin
         if (byteenable[0]) ctrl_reg.word1 <= writedata[word1_lsb +: 5];
         if (byteenable[1]) ctrl_reg.word2 <= writedata[word2_lsb +: 5];
      end
   end

   // phase clock edge history
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phi1_d_reg <= 1'b0;
         phi2_d_reg <= 1'b0;
      end else begin
         phi1_d_reg <= phi1_i;
         phi2_d_reg <= phi2_i;
      end
   end

   // chain advances on phase-1 rise unless inhibited
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_reg <= count_reset;
      end else if (rise1 && !first_stage_inhibit_in_i) begin
         count_reg <= count_reg + 5'h01;
      end
   end

   // one gated pulse per selected state
   // true-logic phase-1 gating
   // decided from the state just before the chain advances
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hit1_reg <= 1'b0;
      end else if (rise1) begin
         hit1_reg <= gate_chain_enable_in_i && |(ctrl_reg.word1 & sel);
      end
   end

   // inverse-logic phase-2 gating
   // sampled on the second clock, so interlaced pulses fill the gaps
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hit2_reg <= 1'b0;
      end else if (rise2) begin
         hit2_reg <= gate_chain_enable_in_i && |(~ctrl_reg.word2 & sel);
      end
   end

   // each output pulses only with its own clock
   // outputs are plain highs, safe to OR outside
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase1_out_o <= 1'b0;
         phase2_out_o <= 1'b0;
      end else begin
         phase1_out_o <= phi1_d_reg & hit1_reg;
         phase2_out_o <= phi2_d_reg & hit2_reg;
      end
   end

   // cascade carries: next chain counts only on our last state
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         inh_carry_reg <= 1'b1;
         en_carry_reg <= 1'b0;
      end else begin
         inh_carry_reg <= !((count_reg == count_last) && !first_stage_inhibit_in_i);
         en_carry_reg <= gate_chain_enable_in_i && (count_reg == count_last);
      end
   end
   assign first_stage_inhibit_carry_out_o = inh_carry_reg;
   assign gate_chain_enable_carry_out_o = en_carry_reg;

   // helper: count phase-1 selections over one full chain period
   // reset leaves the chain at state 0 with nothing counted, so the first
   // period after reset is already a whole one and may be checked
   logic [5:0] pulses_reg;
   logic steady_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pulses_reg <= 6'h00;
         steady_reg <= 1'b1;
      end else if (rise1 && !first_stage_inhibit_in_i && count_reg == count_last) begin
         pulses_reg <= 6'h00;
         steady_reg <= 1'b1;
      end else begin
         if (rise1 && gate_chain_enable_in_i && |(ctrl_reg.word1 & sel)) begin
            pulses_reg <= pulses_reg + 6'h01;
         end
         // a new word at state 0 before any rise still sees a whole period
         if (($changed(ctrl_reg.word1) &&
              (count_reg != count_reset || pulses_reg != 6'h00)) ||
             !gate_chain_enable_in_i || first_stage_inhibit_in_i) begin
            steady_reg <= 1'b0;
         end
      end
   end

   sequence last_rise_s;
      rise1 && !first_stage_inhibit_in_i && count_reg == count_last;
   endsequence

   chk_period_pulse_count: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      last_rise_s and steady_reg |-> pulses_reg == {1'b0, ctrl_reg.word1})
      else $error("phase-1 pulse count differs from control word");

   chk_weight_onehot: assert property (
      @(posedge clk_i) disable iff (!nrst_i) $onehot0(sel))
      else $error("weight selections overlap");

   chk_p1_true_bit: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      rise1 && gate_chain_enable_in_i && !count_reg[0] && ctrl_reg.word1[4]
      |=> hit1_reg ##1 (phase1_out_o == phi1_d_reg) [*1])
      else $error("true-logic bit failed to gate phase-1 pulse");

   chk_p2_inverse_bit: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      rise2 && !count_reg[0] |=>
      hit2_reg == ($past(gate_chain_enable_in_i) && !$past(ctrl_reg.word2[4])))
      else $error("inverse-logic phase-2 gating wrong");

   chk_own_phase_only: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (phase1_out_o |-> $past(phi1_d_reg)) and (phase2_out_o |-> $past(phi2_d_reg)))
      else $error("output pulse without its own clock");

   chk_interlaced_disjoint: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      phase1_out_o && phase2_out_o |-> $past(phi1_d_reg && phi2_d_reg))
      else $error("outputs overlap while clocks interlaced");

   chk_enable_carry: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      gate_chain_enable_in_i && count_reg == count_last && !rise1
      |=> gate_chain_enable_carry_out_o && !first_stage_inhibit_carry_out_o == 
          !$past(first_stage_inhibit_in_i))
      else $error("carry outputs wrong on last state");

   chk_no_carry_early: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      count_reg != count_last |=> first_stage_inhibit_carry_out_o &&
                                  !gate_chain_enable_carry_out_o)
      else $error("carry raised before last state");
endmodule : rate_multiplier
`default_nettype wire

// ---- phase_source.sv ----
// Purpose: far-side logic making interlaced phase clocks
// Assumes: one start pulse gives 32 phase periods
// Notes: both phase clocks stand low outside a run
`timescale 1ns/1ps
`default_nettype none
module phase_source (
   input wire logic clk_i,
   input wire logic start_i,
   output logic busy_o,
   output logic phi1_o,
   output logic phi2_o
);
   logic [7:0] step_reg = 8'h00; // slot in period, period count
   initial busy_o = 1'b0;
   // eight-cycle periods keep every level at least two cycles
   always @(posedge clk_i) begin
      if (start_i) begin
         busy_o <= 1'b1;
         step_reg <= 8'h00;
      end else if (busy_o) begin
         step_reg <= step_reg + 8'h01;
         busy_o <= (step_reg != 8'hff);
      end
   end
   assign phi1_o = busy_o && (step_reg[2:0] < 3'h3);
   assign phi2_o = busy_o && (step_reg[2:0] > 3'h3) && (step_reg[2:0] < 3'h7);
endmodule : phase_source
`default_nettype wire

// ---- binary_rate_multiplier_tb_top.sv ----
// Purpose: self-checking bench for the rate multiplier
// Assumes: bus answers with waitrequest low, phases from phase_source
// Notes: expectations are pulse counts over one full chain period
`timescale 1ns/1ps
`default_nettype none
module binary_rate_multiplier_tb_top;
   import rate_multiplier_pkg::*;
   logic clk_i = 1'b0, nrst_i = 1'b0, start = 1'b0, busy, phi1, phi2;
   logic inh_in = 1'b0, en_in = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
   logic p1, p2, p1_d, p2_d, c2, c2_d, co1;
   logic [3:0] address = 4'h0, byteenable = 4'h0;
   logic [31:0] writedata = 32'h0, readdata, q, seed = 32'h0d4c;
   logic [31:0] n1 = 32'h0, n2 = 32'h0, nc = 32'h0; // rising edges seen
   logic [31:0] nw = 32'h0; // rising edges of the wired-OR train
   logic pw, pw_d;
   // outputs joined as one wired net
   assign pw = p1 | p2;
   logic [4:0] w1, w2;
   int mismatches = 0, total_checks = 0, cycles = 0;
   always #2 clk_i = ~clk_i;
   phase_source src_u (.clk_i(clk_i), .start_i(start), .busy_o(busy),
      .phi1_o(phi1), .phi2_o(phi2));
   rate_multiplier dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .phi1_i(phi1), .phi2_i(phi2),
      .first_stage_inhibit_in_i(inh_in), .gate_chain_enable_in_i(en_in),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .phase1_out_o(p1), .phase2_out_o(p2), .first_stage_inhibit_carry_out_o(co1),
      .gate_chain_enable_carry_out_o(c2));
   // edge counters; a hang past the ceiling ends the run
   always @(posedge clk_i) begin
      p1_d <= p1;
      p2_d <= p2;
      c2_d <= c2;
      pw_d <= pw;
      if (pw === 1'b1 && pw_d === 1'b0) nw <= nw + 1;
      if (p1 === 1'b1 && p1_d === 1'b0) n1 <= n1 + 1;
      if (p2 === 1'b1 && p2_d === 1'b0) n2 <= n2 + 1;
      if (c2 === 1'b1 && c2_d === 1'b0) nc <= nc + 1;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one request, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
         input logic [3:0] be);
      @(posedge clk_i);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= wr;
      read <= !wr;
      // only the bench ceiling ends a wait that never answers
      do begin
         @(posedge clk_i);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   // one full chain period; the 2-cycle output lag is let drain
   task automatic run(input logic [31:0] e1, input logic [31:0] e2, input logic [31:0] ec);
      logic [31:0] a1, a2, ac, aw;
      @(posedge clk_i);
      aw = nw;
      a1 = n1;
      a2 = n2;
      ac = nc;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk_i);
      repeat (6) @(posedge clk_i);
      check(n1 - a1, e1); // phase-1 pulse count
      check(n2 - a2, e2); // phase-2 inverse count
      check(nc - ac, ec); // one carry per period
      check(nw - aw, e1 + e2); // interlaced train keeps every pulse
   endtask : run
   task automatic report_and_stop();
      if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      bus(1'b0, ctrl_addr, 32'h0, 4'hf);
      check(q & 32'h1f1f, {19'h0, word2_reset, 3'h0, word1_reset}); // words idle
      bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      check(q, 32'h0); // unmapped reads zero
      // single stage, random words after corners
      for (int i = 0; i < 7; i++) begin
         seed = xs(seed);
         w1 = (i == 0) ? 5'h15 : (i == 1) ? 5'h1f : (i == 2) ? 5'h00 : seed[4:0];
         w2 = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : (i == 2) ? 5'h0a : seed[12:8];
         bus(1'b1, ctrl_addr, {19'h0, w2, 3'h0, w1}, 4'h3);
         run({27'h0, w1}, {27'h0, ~w2}, 32'h1);
      end
      bus(1'b1, ctrl_addr, 32'h00000010, 4'h1);
      bus(1'b0, ctrl_addr, 32'h0, 4'hf);
      check(q & 32'h1f1f, {19'h0, w2, 8'h10}); // lane one untouched
      bus(1'b1, ctrl_addr, 32'h00001f00, 4'h2);
      en_in <= 1'b0;
      run(32'h0, 32'h0, 32'h0); // closed gate chain
      en_in <= 1'b1;
      inh_in <= 1'b1;
      run(32'h20, 32'h0, 32'h0); // held chain still gates state 0
      bus(1'b0, status_addr, 32'h0, 4'hf);
      check(q & 32'h1f, 32'h0); // count held
      inh_in <= 1'b0;
      report_and_stop();
   end
endmodule : binary_rate_multiplier_tb_top
`default_nettype wire
